// ### pkg/usb_ep_pkg.sv
// package: register map, fifo geometry and carrier types of the endpoint fifo block
package usb_ep_pkg;
    localparam int NUM_EP = 7;
    localparam int MEM_BYTES = 264;
    // fifo depth and base per endpoint, entry 0 is the control endpoint
    localparam logic [6:0][6:0] FIFO_SIZE = {7'h40, 7'h40, 7'h20, 7'h20, 7'h20, 7'h20, 7'h08};
    localparam logic [6:0][8:0] FIFO_BASE = {9'h0C8, 9'h088, 9'h068, 9'h048, 9'h028, 9'h008,
                                             9'h000};
    localparam logic [6:0] TX_EP_MASK = 7'h2B;
    localparam logic [6:0] RX_EP_MASK = 7'h55;
    localparam logic [6:0] DEFAULT_ADDR = 7'h00;

    // apb byte offsets: region in paddr[6:5], word in paddr[4:2]
    localparam logic [1:0] REGION_CTRL = 2'h0;
    localparam logic [1:0] REGION_CMD = 2'h1;
    localparam logic [1:0] REGION_STAT = 2'h2;
    localparam logic [1:0] REGION_DATA = 2'h3;
    localparam logic [11:0] FUNC_ADDR_OFFSET = 12'h000;
    localparam logic [11:0] EPC_OFFSET = 12'h004;
    localparam logic [11:0] CMD_OFFSET = 12'h020;
    localparam logic [11:0] STAT_OFFSET = 12'h040;
    localparam logic [11:0] DATA_OFFSET = 12'h060;

    localparam int FUNC_ADDR_EN_BIT = 7;
    localparam int EPC_EN_BIT = 4;
    localparam int EPC_ISO_BIT = 5;
    localparam int EPC_DEFAULT_BIT = 6;
    localparam int EPC_RXEN_BIT = 7;
    localparam int CMD_LAST_BIT = 8;
    localparam int CMD_FLUSH_BIT = 9;
    localparam int STAT_XRUN_BIT = 8;
    localparam int STAT_WARN_BIT = 9;
    localparam int STAT_DONE_BIT = 10;

    localparam logic [7:0] FUNC_ADDR_RESET = 8'h00;
    localparam logic [7:0] EPC_RESET = 8'h00;
    localparam logic [6:0] THR_RESET = 7'h00;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_RX = 3'b010,
        PH_TX = 3'b100
    } phase_type;

    typedef struct packed {
        logic tok_valid;
        logic tok_in;
        logic [6:0] tok_addr;
        logic [3:0] tok_ep;
        logic rx_valid;
        logic [7:0] rx_data;
        logic rx_end;
        logic rx_err;
        logic tx_req;
        logic tx_end;
        logic tx_err;
    } sie_in_type;

    typedef struct packed {
        logic match;
        logic [2:0] match_ep;
        logic tx_valid;
        logic [7:0] tx_data;
        logic tx_last;
        logic tx_underrun;
    } sie_out_type;

    typedef struct packed {
        logic [7:0] function_address_reg;
        logic [6:0][7:0] epc;
        logic [6:0][6:0] thr;
        logic [6:0] last_cmd;
        logic [6:0][6:0] wp;
        logic [6:0][6:0] rp;
        logic [6:0][6:0] cnt;
        logic [6:0] xrun;
        logic [6:0] done;
        phase_type phase;
        logic [2:0] act_ep;
        logic [MEM_BYTES-1:0][7:0] mem;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        sie_out_type out;
    } state_type;
endpackage

// ### rtl/usb_endpoint_fifo_decode.sv
// endpoint address decode and fifo storage with apb register access
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module usb_endpoint_fifo_decode (
    input wire logic pclk, // 250 mhz bus and fifo clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error for unmapped word
    input wire usb_ep_pkg::sie_in_type sie_in, // token, receive and transmit requests
    output usb_ep_pkg::sie_out_type sie_out // decode result and transmit bytes
);
    usb_ep_pkg::state_type s;
    usb_ep_pkg::state_type next_s;

    logic apb_setup;
    logic apb_done;
    logic [1:0] region;
    logic [2:0] word;
    logic [6:0] push;
    logic [6:0] pop;
    logic [6:0] flush;
    logic [6:0] retry;
    logic [6:0][7:0] push_data;
    logic [6:0] is_tx;
    logic [6:0] warn;
    logic addr_ok;
    logic default_ok;
    logic hit;
    logic [2:0] sel;

    assign apb_setup = psel & ~penable;
    assign apb_done = psel & penable & s.pready;
    assign region = paddr[6:5];
    assign word = paddr[4:2];

    // control endpoint direction follows its receive enable
    always_comb begin
        for (int i = 0; i < usb_ep_pkg::NUM_EP; i++) begin
            if (i == 0) begin
                is_tx[i] = ~s.epc[0][usb_ep_pkg::EPC_RXEN_BIT];
            end else begin
                is_tx[i] = usb_ep_pkg::TX_EP_MASK[i];
            end
            if (is_tx[i]) begin
                warn[i] = s.cnt[i] <= s.thr[i];
            end else begin
                warn[i] = (usb_ep_pkg::FIFO_SIZE[i] - s.cnt[i]) <= s.thr[i];
            end
        end
    end

    // token decode: scanning high to low lets the lowest match win
    always_comb begin
        logic en;
        logic skip;
        en = 1'b0;
        skip = 1'b0;
        addr_ok = s.function_address_reg[usb_ep_pkg::FUNC_ADDR_EN_BIT] &&
                  sie_in.tok_addr == s.function_address_reg[6:0];
        default_ok = s.epc[0][usb_ep_pkg::EPC_DEFAULT_BIT] &&
                     sie_in.tok_addr == usb_ep_pkg::DEFAULT_ADDR;
        hit = 1'b0;
        sel = 3'h0;
        for (int i = usb_ep_pkg::NUM_EP - 1; i >= 0; i--) begin
            if (i == 0) begin
                // is relied on: only one control direction is ever enabled
                en = sie_in.tok_in ? s.epc[0][usb_ep_pkg::EPC_EN_BIT]
                                   : s.epc[0][usb_ep_pkg::EPC_RXEN_BIT];
                skip = !sie_in.tok_in && s.done[0];
            end else begin
                en = s.epc[i][usb_ep_pkg::EPC_EN_BIT] && (sie_in.tok_in ?
                     usb_ep_pkg::TX_EP_MASK[i] : usb_ep_pkg::RX_EP_MASK[i]);
                skip = s.epc[i][usb_ep_pkg::EPC_ISO_BIT] && (sie_in.tok_in ?
                       s.cnt[i] == 7'h00 : s.cnt[i] == usb_ep_pkg::FIFO_SIZE[i]);
            end
            if (en && !skip && s.epc[i][3:0] == sie_in.tok_ep &&
                (addr_ok || (i == 0 && default_ok))) begin
                hit = 1'b1;
                sel = 3'(i);
            end
        end
    end

    always_comb begin
        logic [2:0] e;
        logic [8:0] idx;
        logic [6:0] prev;
        e = s.act_ep;
        idx = 9'h000;
        prev = 7'h00;
        next_s = s;
        push = 7'h00;
        pop = 7'h00;
        flush = 7'h00;
        retry = 7'h00;
        push_data = '0;
        next_s.out.match = 1'b0;
        next_s.out.tx_valid = 1'b0;
        next_s.out.tx_last = 1'b0;
        next_s.out.tx_underrun = 1'b0;
        next_s.pready = apb_setup;
        next_s.pslverr = 1'b0;

        // read data is prepared at setup so it stands through the access phase
        if (apb_setup) begin
            next_s.prdata = 32'h0000_0000;
            unique case (region)
                usb_ep_pkg::REGION_CTRL: begin
                    if (word == 3'h0) begin
                        next_s.prdata[7:0] = s.function_address_reg;
                    end else begin
                        next_s.prdata[7:0] = s.epc[word - 3'h1];
                    end
                end
                usb_ep_pkg::REGION_CMD: begin
                    if (word == 3'h7) begin
                        next_s.pslverr = 1'b1;
                    end else begin
                        next_s.prdata[6:0] = s.thr[word];
                        next_s.prdata[usb_ep_pkg::CMD_LAST_BIT] = s.last_cmd[word];
                    end
                end
                usb_ep_pkg::REGION_STAT: begin
                    if (word == 3'h7) begin
                        next_s.pslverr = 1'b1;
                    end else begin
                        next_s.prdata[6:0] = is_tx[word] ?
                            usb_ep_pkg::FIFO_SIZE[word] - s.cnt[word] : s.cnt[word];
                        next_s.prdata[usb_ep_pkg::STAT_XRUN_BIT] = s.xrun[word];
                        next_s.prdata[usb_ep_pkg::STAT_WARN_BIT] = warn[word];
                        next_s.prdata[usb_ep_pkg::STAT_DONE_BIT] = s.done[word];
                    end
                end
                usb_ep_pkg::REGION_DATA: begin
                    if (word == 3'h7) begin
                        next_s.pslverr = 1'b1;
                    end else begin
                        prev = (s.rp[word] == 7'h00) ? usb_ep_pkg::FIFO_SIZE[word] - 7'h01
                                                     : s.rp[word] - 7'h01;
                        idx = usb_ep_pkg::FIFO_BASE[word] +
                              9'((s.cnt[word] == 7'h00) ? prev : s.rp[word]);
                        next_s.prdata[7:0] = s.mem[idx];
                    end
                end
                default: next_s.pslverr = 1'b1;
            endcase
            if (paddr[11:7] != 5'h00 || paddr[1:0] != 2'h0) begin
                next_s.pslverr = 1'b1;
            end
        end

        // writes and pops take effect only at the completing edge
        if (apb_done && !s.pslverr) begin
            if (pwrite) begin
                unique case (region)
                    usb_ep_pkg::REGION_CTRL: begin
                        if (word == 3'h0) begin
                            next_s.function_address_reg = pwdata[7:0];
                        end else begin
                            next_s.epc[word - 3'h1] = pwdata[7:0];
                        end
                    end
                    usb_ep_pkg::REGION_CMD: begin
                        next_s.thr[word] = pwdata[6:0];
                        next_s.last_cmd[word] = pwdata[usb_ep_pkg::CMD_LAST_BIT];
                        flush[word] = pwdata[usb_ep_pkg::CMD_FLUSH_BIT];
                    end
                    usb_ep_pkg::REGION_STAT: begin
                        // write one to clear; a hardware set below still wins
                        if (pwdata[usb_ep_pkg::STAT_XRUN_BIT]) begin
                            next_s.xrun[word] = 1'b0;
                        end
                        if (pwdata[usb_ep_pkg::STAT_DONE_BIT]) begin
                            next_s.done[word] = 1'b0;
                        end
                    end
                    default: begin
                        if (is_tx[word] && s.cnt[word] != usb_ep_pkg::FIFO_SIZE[word]) begin
                            push[word] = 1'b1;
                            push_data[word] = pwdata[7:0];
                        end
                    end
                endcase
            end else if (region == usb_ep_pkg::REGION_DATA && !is_tx[word] &&
                         s.cnt[word] != 7'h00) begin
                pop[word] = 1'b1;
            end
        end

        if (sie_in.tok_valid) begin
            next_s.phase = usb_ep_pkg::PH_IDLE;
            if (hit) begin
                next_s.phase = sie_in.tok_in ? usb_ep_pkg::PH_TX : usb_ep_pkg::PH_RX;
                next_s.act_ep = sel;
                next_s.out.match = 1'b1;
                next_s.out.match_ep = sel;
            end
        end else if (s.phase == usb_ep_pkg::PH_RX) begin
            if (sie_in.rx_valid) begin
                if (s.cnt[e] == usb_ep_pkg::FIFO_SIZE[e]) begin
                    next_s.xrun[e] = 1'b1;
                end else begin
                    push[e] = 1'b1;
                    push_data[e] = sie_in.rx_data;
                end
            end
            if (sie_in.rx_end) begin
                next_s.phase = usb_ep_pkg::PH_IDLE;
                if (e == 3'h0 && sie_in.rx_err) begin
                    flush[0] = 1'b1;
                end else begin
                    next_s.done[e] = 1'b1;
                end
            end
        end else if (s.phase == usb_ep_pkg::PH_TX) begin
            if (sie_in.tx_req) begin
                if (s.cnt[e] != 7'h00) begin
                    pop[e] = 1'b1;
                    next_s.out.tx_valid = 1'b1;
                    next_s.out.tx_data = s.mem[usb_ep_pkg::FIFO_BASE[e] + 9'(s.rp[e])];
                end else if (s.last_cmd[e]) begin
                    next_s.out.tx_last = 1'b1;
                end else begin
                    next_s.out.tx_underrun = 1'b1;
                    next_s.xrun[e] = 1'b1;
                end
            end
            if (sie_in.tx_end) begin
                next_s.phase = usb_ep_pkg::PH_IDLE;
                if (e == 3'h0 && sie_in.tx_err) begin
                    retry[0] = 1'b1;
                end else begin
                    next_s.done[e] = 1'b1;
                end
            end
        end

        // control packet always starts at zero, so a retry rewinds the reader there
        for (int i = 0; i < usb_ep_pkg::NUM_EP; i++) begin
            if (flush[i]) begin
                next_s.wp[i] = 7'h00;
                next_s.rp[i] = 7'h00;
                next_s.cnt[i] = 7'h00;
                next_s.done[i] = 1'b0;
            end else if (retry[i]) begin
                next_s.rp[i] = 7'h00;
                next_s.cnt[i] = s.wp[i];
            end else begin
                if (push[i]) begin
                    next_s.mem[usb_ep_pkg::FIFO_BASE[i] + 9'(s.wp[i])] = push_data[i];
                    next_s.wp[i] = (s.wp[i] == usb_ep_pkg::FIFO_SIZE[i] - 7'h01) ?
                                   7'h00 : s.wp[i] + 7'h01;
                end
                if (pop[i]) begin
                    next_s.rp[i] = (s.rp[i] == usb_ep_pkg::FIFO_SIZE[i] - 7'h01) ?
                                   7'h00 : s.rp[i] + 7'h01;
                end
                next_s.cnt[i] = s.cnt[i] + 7'(push[i]) - 7'(pop[i]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.function_address_reg <= usb_ep_pkg::FUNC_ADDR_RESET;
            s.epc <= {usb_ep_pkg::NUM_EP{usb_ep_pkg::EPC_RESET}};
            s.thr <= {usb_ep_pkg::NUM_EP{usb_ep_pkg::THR_RESET}};
            s.phase <= usb_ep_pkg::PH_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign sie_out = s.out;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic tx_full_write;
    logic rx_phase0;
    assign tx_full_write = apb_done && pwrite && !s.pslverr && region == usb_ep_pkg::REGION_DATA
                           && word == 3'h1 && s.cnt[1] == usb_ep_pkg::FIFO_SIZE[1];
    assign rx_phase0 = s.phase == usb_ep_pkg::PH_RX && s.act_ep == 3'h0;

    property p_apb_one_wait;
        apb_setup |=> pready ##1 !pready;
    endproperty
    a_apb_one_wait: assert property (p_apb_one_wait) else $error("apb answer not one cycle");

    property p_no_match;
        sie_in.tok_valid && !hit |=> s.phase == usb_ep_pkg::PH_IDLE && !sie_out.match;
    endproperty
    a_no_match: assert property (p_no_match) else $error("unmatched token took effect");

    property p_full_drop;
        tx_full_write && !(s.phase == usb_ep_pkg::PH_TX && sie_in.tx_req) |=>
            s.cnt[1] == usb_ep_pkg::FIFO_SIZE[1] && s.wp[1] == $past(s.wp[1]);
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("write into full fifo stored");

    property p_underrun;
        s.phase == usb_ep_pkg::PH_TX && !sie_in.tok_valid && sie_in.tx_req &&
            s.cnt[s.act_ep] == 7'h00 && !s.last_cmd[s.act_ep] |=>
            sie_out.tx_underrun && !sie_out.tx_valid;
    endproperty
    a_underrun: assert property (p_underrun) else $error("underrun not reported");

    property p_tx_byte;
        s.phase == usb_ep_pkg::PH_TX && !sie_in.tok_valid && sie_in.tx_req &&
            s.cnt[s.act_ep] != 7'h00 |=> sie_out.tx_valid && !sie_out.tx_underrun;
    endproperty
    a_tx_byte: assert property (p_tx_byte) else $error("byte not sent");

    property p_cnt_bound;
        s.cnt[6] <= usb_ep_pkg::FIFO_SIZE[6] && s.cnt[0] <= usb_ep_pkg::FIFO_SIZE[0];
    endproperty
    a_cnt_bound: assert property (p_cnt_bound) else $error("fifo level beyond depth");

    property p_flush;
        apb_done && pwrite && !s.pslverr && region == usb_ep_pkg::REGION_CMD && word == 3'h0 &&
            pwdata[usb_ep_pkg::CMD_FLUSH_BIT] |=> s.cnt[0] == 7'h00 && s.wp[0] == 7'h00;
    endproperty
    a_flush: assert property (p_flush) else $error("flush left data");

    property p_crc_discard;
        rx_phase0 && !sie_in.tok_valid && sie_in.rx_end && sie_in.rx_err |=>
            s.cnt[0] == 7'h00 && !s.done[0] && s.phase == usb_ep_pkg::PH_IDLE;
    endproperty
    a_crc_discard: assert property (p_crc_discard) else $error("bad packet kept");

    property p_retry;
        s.phase == usb_ep_pkg::PH_TX && s.act_ep == 3'h0 && !sie_in.tok_valid &&
            sie_in.tx_end && sie_in.tx_err && !flush[0] |=> s.rp[0] == 7'h00 && s.cnt[0] == s.wp[0];
    endproperty
    a_retry: assert property (p_retry) else $error("control packet not kept");

    c_rx_packet: cover property (rx_phase0 ##[1:20] sie_in.rx_end && !sie_in.rx_err);
    c_tx_stream: cover property (sie_out.tx_valid ##1 sie_out.tx_valid ##1 sie_out.tx_valid);
    c_underrun: cover property (sie_out.tx_underrun);
    c_ping_pong: cover property (sie_out.match && sie_out.match_ep == 3'h4);
endmodule
`default_nettype wire

// ### sim/usb_host_sie_model.sv
// host side model: drives token and data pulses into the block, logs its answers
`timescale 1ns/1ns
`default_nettype none
module usb_host_sie_model (
    input wire logic pclk, // block clock
    output usb_ep_pkg::sie_in_type sie_in, // pulses toward the block
    input wire usb_ep_pkg::sie_out_type sie_out // answers from the block
);
    int n_match = 0;
    int n_under = 0;
    int n_last = 0;
    logic [2:0] match_ep = 3'h0;
    logic [7:0] txq[$];

    initial sie_in = '0;

    always @(posedge pclk) begin
        if (sie_out.match) begin
            n_match <= n_match + 1;
            match_ep <= sie_out.match_ep;
        end
        if (sie_out.tx_valid) begin
            txq.push_back(sie_out.tx_data);
        end
        if (sie_out.tx_underrun) begin
            n_under <= n_under + 1;
        end
        if (sie_out.tx_last) begin
            n_last <= n_last + 1;
        end
    end

    // released data line shows the inverse so a stale byte is never read as valid
    task automatic pulse(input usb_ep_pkg::sie_in_type v);
        usb_ep_pkg::sie_in_type idle;
        idle = '0;
        idle.rx_data = ~v.rx_data;
        @(posedge pclk);
        sie_in <= v;
        @(posedge pclk);
        sie_in <= idle;
        repeat (2) @(posedge pclk);
    endtask

    task automatic token(input logic tin, input logic [6:0] a, input logic [3:0] e);
        usb_ep_pkg::sie_in_type v;
        v = '0;
        v.tok_valid = 1'b1;
        v.tok_in = tin;
        v.tok_addr = a;
        v.tok_ep = e;
        pulse(v);
    endtask

    task automatic rx_byte(input logic [7:0] d);
        usb_ep_pkg::sie_in_type v;
        v = '0;
        v.rx_valid = 1'b1;
        v.rx_data = d;
        pulse(v);
    endtask

    task automatic finish_pkt(input logic tx, input logic err);
        usb_ep_pkg::sie_in_type v;
        v = '0;
        v.rx_end = ~tx;
        v.tx_end = tx;
        v.rx_err = ~tx & err;
        v.tx_err = tx & err;
        pulse(v);
    endtask

    task automatic pull();
        usb_ep_pkg::sie_in_type v;
        v = '0;
        v.tx_req = 1'b1;
        pulse(v);
    endtask
endmodule
`default_nettype wire

// ### sim/usb_endpoint_fifo_decode_tb_top.sv
// self-checking bench: apb register access and fifo traffic against the host model
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, w) chk((g), (w))
module usb_endpoint_fifo_decode_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    usb_ep_pkg::sie_in_type sie_in;
    usb_ep_pkg::sie_out_type sie_out;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic rerr;

    usb_endpoint_fifo_decode u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sie_in(sie_in),
        .sie_out(sie_out));
    usb_host_sie_model u_host (.pclk(pclk), .sie_in(sie_in), .sie_out(sie_out));

    always #2 pclk = ~pclk;

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // a hang is cut short well above the few hundred cycles the sequence needs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            $display("Error at %0t: timeout", $time);
            conclude();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] w);
        checks_done++;
        if (g !== w) begin
            err_count++;
            $display("Error at %0t: got %h want %h", $time, g, w);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no fixed latency assumed: only the bench timeout ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        int i;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, 12'h044, 32'h0);
        `CHK(rd[6:0], usb_ep_pkg::FIFO_SIZE[1]);
        `CHK(rd[9], 1'b1);
        xfer(1'b0, 12'h048, 32'h0);
        `CHK(rd[6:0], 7'h00);
        xfer(1'b0, 12'h080, 32'h0);
        `CHK(rerr, 1'b1);
        xfer(1'b1, 12'h000, 32'h00000085);
        xfer(1'b1, 12'h008, 32'h00000011);
        xfer(1'b1, 12'h00C, 32'h00000012);
        xfer(1'b1, 12'h028, 32'h0000001C);
        for (i = 0; i < 3; i++) xfer(1'b1, 12'h064, 32'hA0 + i);
        xfer(1'b0, 12'h044, 32'h0);
        `CHK(rd[6:0], usb_ep_pkg::FIFO_SIZE[1] - 7'h03);
        `CHK(rd[9], 1'b0);
        u_host.token(1'b1, 7'h06, 4'h1);
        u_host.token(1'b1, 7'h05, 4'h3);
        `CHK(u_host.n_match, 0);
        u_host.token(1'b1, 7'h05, 4'h1);
        `CHK(u_host.n_match, 1);
        `CHK(u_host.match_ep, 3'h1);
        repeat (4) u_host.pull();
        u_host.finish_pkt(1'b1, 1'b0);
        `CHK(u_host.txq.size(), 3);
        for (i = 0; i < 3; i++) `CHK(u_host.txq[i], 8'hA0 + i);
        `CHK(u_host.n_under, 1);
        xfer(1'b0, 12'h044, 32'h0);
        `CHK(rd[8], 1'b1);
        `CHK(rd[6:0], usb_ep_pkg::FIFO_SIZE[1]);
        for (i = 0; i < 33; i++) xfer(1'b1, 12'h064, 32'h50 + i);
        xfer(1'b0, 12'h044, 32'h0);
        `CHK(rd[6:0], 7'h00);
        u_host.token(1'b1, 7'h05, 4'h1);
        u_host.pull();
        `CHK(u_host.txq[3], 8'h50);
        xfer(1'b1, 12'h024, 32'h00000200);
        xfer(1'b0, 12'h044, 32'h0);
        `CHK(rd[6:0], usb_ep_pkg::FIFO_SIZE[1]);
        u_host.token(1'b0, 7'h05, 4'h2);
        `CHK(u_host.match_ep, 3'h2);
        for (i = 1; i < 5; i++) u_host.rx_byte(8'h11 * i);
        u_host.finish_pkt(1'b0, 1'b0);
        xfer(1'b0, 12'h048, 32'h0);
        `CHK(rd[6:0], 7'h04);
        `CHK(rd[9], 1'b1);
        for (i = 1; i < 6; i++) begin
            xfer(1'b0, 12'h068, 32'h0);
            `CHK(rd[7:0], 8'h11 * ((i > 4) ? 4 : i));
        end
        xfer(1'b0, 12'h048, 32'h0);
        `CHK(rd[6:0], 7'h00);
        // only the receive direction of the control endpoint is enabled
        xfer(1'b1, 12'h004, 32'h000000C0);
        u_host.token(1'b0, usb_ep_pkg::DEFAULT_ADDR, 4'h0);
        `CHK(u_host.n_match, 4);
        `CHK(u_host.match_ep, 3'h0);
        // control endpoint: bad packet dropped, good one flagged and blocking the next OUT
        u_host.rx_byte(8'h5A);
        u_host.finish_pkt(1'b0, 1'b1);
        xfer(1'b0, 12'h040, 32'h0);
        `CHK(rd[10:0], 11'h000);
        u_host.token(1'b0, usb_ep_pkg::DEFAULT_ADDR, 4'h0);
        for (i = 0; i < 2; i++) u_host.rx_byte(8'h61 + 8'(i));
        u_host.finish_pkt(1'b0, 1'b0);
        xfer(1'b0, 12'h040, 32'h0);
        `CHK(rd[10:0], 11'h402);
        u_host.token(1'b0, usb_ep_pkg::DEFAULT_ADDR, 4'h0);
        `CHK(u_host.n_match, 5);
        // control endpoint turned to transmit: flush, load, send, resend after an error
        xfer(1'b1, 12'h004, 32'h00000010);
        xfer(1'b1, 12'h020, 32'h00000200);
        xfer(1'b0, 12'h040, 32'h0);
        `CHK(rd[6:0], usb_ep_pkg::FIFO_SIZE[0]);
        xfer(1'b1, 12'h060, 32'h000000C1);
        xfer(1'b1, 12'h060, 32'h000000C2);
        xfer(1'b1, 12'h020, 32'h00000100);
        u_host.token(1'b1, 7'h05, 4'h0);
        repeat (3) u_host.pull();
        `CHK(u_host.n_last, 1);
        u_host.finish_pkt(1'b1, 1'b1);
        u_host.token(1'b1, 7'h05, 4'h0);
        repeat (2) u_host.pull();
        `CHK(u_host.txq.size(), 8);
        `CHK(u_host.txq[6], 8'hC1);
        `CHK(u_host.txq[7], 8'hC2);
        // two iso receive endpoints on one number: the lower fills, then the higher takes over
        xfer(1'b1, 12'h00C, 32'h00000035);
        xfer(1'b1, 12'h014, 32'h00000035);
        u_host.token(1'b0, 7'h05, 4'h5);
        `CHK(u_host.match_ep, 3'h2);
        for (i = 0; i < 33; i++) u_host.rx_byte(8'(i));
        u_host.finish_pkt(1'b0, 1'b0);
        xfer(1'b0, 12'h048, 32'h0);
        `CHK(rd[6:0], usb_ep_pkg::FIFO_SIZE[2]);
        `CHK(rd[8], 1'b1);
        u_host.token(1'b0, 7'h05, 4'h5);
        `CHK(u_host.match_ep, 3'h4);
        conclude();
    end
endmodule
`default_nettype wire
